// File: src/cdb_pkg.sv
// Notes on behaviour
// - Register zeroize writes 00h to the addressed file register and sets null flag.
// - Accumulator zeroize loads 00h into accumulator and sets null flag.
// - Watchdog kick clears watchdog counter and its prescaler.
// - Watchdog kick sets expiry and sleep entry flags; other flags keep value.
// - Invert complements the file register, updating only the null flag.
// - Destination bit 0 sends result to accumulator, 1 back to file register.
// - Minus one decrements file register into destination and updates null flag.
// - Minus one skip decrements into destination, leaving all flags unchanged.
// - Zero skip result discards next fetched instruction as no-operation, two cycles.
// - Far jump loads its 11-bit literal into program counter bits 10..0.
// - Far jump takes program counter bits 12..11 from latch bits 4..3.
// - Far jump is unconditional, touches no flag, takes two instruction cycles.
package cdb_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int FILE_ADDR_W = 7;
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int LIT_W = 11;
    localparam int LATCH_HI_BIT = 4;
    localparam int LATCH_LO_BIT = 3;
    localparam int DEST_BIT = 7;

    // ************************************************************
    // Instruction encodings
    // ************************************************************
    localparam logic [13:0] ZEROIZE_MASK = 14'h3F80;
    localparam logic [13:0] ZEROIZE_VAL = 14'h0180;
    localparam logic [13:0] ACC_ZEROIZE_MASK = 14'h3F80;
    localparam logic [13:0] ACC_ZEROIZE_VAL = 14'h0100;
    localparam logic [13:0] KICK_MASK = 14'h3FFF;
    localparam logic [13:0] KICK_VAL = 14'h0064;
    localparam logic [13:0] INVERT_MASK = 14'h3F00;
    localparam logic [13:0] INVERT_VAL = 14'h0900;
    localparam logic [13:0] MINUS_MASK = 14'h3F00;
    localparam logic [13:0] MINUS_VAL = 14'h0300;
    localparam logic [13:0] SKIP_MASK = 14'h3F00;
    localparam logic [13:0] SKIP_VAL = 14'h0B00;
    localparam logic [13:0] JUMP_MASK = 14'h3800;
    localparam logic [13:0] JUMP_VAL = 14'h2800;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] OFS_LATCH = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_ACC = 12'h008;
    localparam logic [11:0] OFS_TARGET = 12'h00C;
    localparam int ST_NULL_BIT = 0;
    localparam int ST_SLEEP_BIT = 1;
    localparam int ST_EXPIRY_BIT = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [12:0] RST_TARGET = 13'h0000;
    localparam logic RST_NULL = 1'b0;
    localparam logic RST_EXPIRY = 1'b1;
    localparam logic RST_SLEEP = 1'b1;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        CDB_ALU_ZERO,
        CDB_ALU_INVERT,
        CDB_ALU_MINUS_ONE
    } cdb_alu_op_type;

    typedef enum logic {
        CDB_EXEC,
        CDB_SQUASH
    } cdb_state_type;

endpackage

// File: src/cdb_alu_if.sv
`timescale 1ns/1ps
interface cdb_alu_if;
    import cdb_pkg::*;
    cdb_alu_op_type op;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic is_null;

    modport core (output op, output operand, input result, input is_null);
    modport alu (input op, input operand, output result, output is_null);
endinterface

// File: src/cdb_alu.sv
`timescale 1ns/1ps
module cdb_alu
    import cdb_pkg::*;
#(
    parameter int W = DATA_W
) (
    cdb_alu_if.alu bus
);

    initial begin
        if (W != DATA_W) begin
            $error("cdb_alu width must equal the data width");
        end
    end

    always_comb begin
        case (bus.op)
            CDB_ALU_ZERO: begin
                bus.result = '0;
            end
            CDB_ALU_INVERT: begin
                bus.result = ~bus.operand;
            end
            CDB_ALU_MINUS_ONE: begin
                bus.result = bus.operand - 8'h01;
            end
            default: begin
                bus.result = '0;
            end
        endcase
        bus.is_null = (bus.result == '0);
    end

endmodule

// File: src/cdb_exec.sv
`timescale 1ns/1ps
module cdb_exec
    import cdb_pkg::*;
#(
    parameter int DW = DATA_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction from decode
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr_word,
    // File register port
    output logic [FILE_ADDR_W-1:0] file_raddr,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic file_we,
    output logic [FILE_ADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    // Watchdog
    output logic watchdog_clear,
    input wire logic watchdog_expire_evt,
    input wire logic sleep_evt,
    // Program counter
    output logic pc_load,
    output logic [PC_W-1:0] pc_target,
    output logic squash_active
);

    initial begin
        if (DW != DATA_W) begin
            $error("cdb_exec data width must be 8");
        end
    end

    // ************************************************************
    // Datapath helper
    // ************************************************************
    cdb_alu_if alu_bus ();

    cdb_alu #(
        .W(DATA_W)
    ) u_alu (
        .bus(alu_bus)
    );

    // ************************************************************
    // Decode
    // ************************************************************
    logic do_zeroize;
    logic do_acc_zeroize;
    logic do_kick;
    logic do_invert;
    logic do_minus;
    logic do_skip;
    logic do_jump;
    logic dest_file;

    assign do_zeroize = (instr_word & ZEROIZE_MASK) == ZEROIZE_VAL;
    assign do_acc_zeroize = (instr_word & ACC_ZEROIZE_MASK) == ACC_ZEROIZE_VAL;
    assign do_kick = (instr_word & KICK_MASK) == KICK_VAL;
    assign do_invert = (instr_word & INVERT_MASK) == INVERT_VAL;
    assign do_minus = (instr_word & MINUS_MASK) == MINUS_VAL;
    assign do_skip = (instr_word & SKIP_MASK) == SKIP_VAL;
    assign do_jump = (instr_word & JUMP_MASK) == JUMP_VAL;
    assign dest_file = instr_word[DEST_BIT];
    assign file_raddr = instr_word[FILE_ADDR_W-1:0];

    always_comb begin
        alu_bus.operand = file_rdata;
        if (do_invert) begin
            alu_bus.op = CDB_ALU_INVERT;
        end else if (do_minus || do_skip) begin
            alu_bus.op = CDB_ALU_MINUS_ONE;
        end else begin
            alu_bus.op = CDB_ALU_ZERO;
        end
    end

    // ************************************************************
    // Execution state
    // ************************************************************
    cdb_state_type state_r;
    cdb_state_type state_nxt;
    logic [DATA_W-1:0] acc_r;
    logic [DATA_W-1:0] acc_nxt;
    logic null_r;
    logic null_nxt;
    logic expiry_r;
    logic expiry_nxt;
    logic sleep_r;
    logic sleep_nxt;
    logic file_we_r;
    logic file_we_nxt;
    logic [FILE_ADDR_W-1:0] file_waddr_r;
    logic [FILE_ADDR_W-1:0] file_waddr_nxt;
    logic [DATA_W-1:0] file_wdata_r;
    logic [DATA_W-1:0] file_wdata_nxt;
    logic wd_clear_r;
    logic wd_clear_nxt;
    logic pc_load_r;
    logic pc_load_nxt;
    logic [PC_W-1:0] target_r;
    logic [PC_W-1:0] target_nxt;
    logic [DATA_W-1:0] latch_r;
    logic [DATA_W-1:0] latch_nxt;

    always_comb begin
        state_nxt = state_r;
        acc_nxt = acc_r;
        null_nxt = null_r;
        expiry_nxt = expiry_r;
        sleep_nxt = sleep_r;
        file_we_nxt = 1'b0;
        file_waddr_nxt = file_waddr_r;
        file_wdata_nxt = file_wdata_r;
        wd_clear_nxt = 1'b0;
        pc_load_nxt = 1'b0;
        target_nxt = target_r;
        if (instr_valid) begin
            case (state_r)
                CDB_SQUASH: begin
                    // Fetched word is dropped and runs as a no-operation
                    state_nxt = CDB_EXEC;
                end
                CDB_EXEC: begin
                    if (do_zeroize) begin
                        file_we_nxt = 1'b1;
                        file_waddr_nxt = instr_word[FILE_ADDR_W-1:0];
                        file_wdata_nxt = alu_bus.result;
                        null_nxt = 1'b1;
                    end else if (do_acc_zeroize) begin
                        acc_nxt = alu_bus.result;
                        null_nxt = 1'b1;
                    end else if (do_kick) begin
                        wd_clear_nxt = 1'b1;
                        expiry_nxt = 1'b1;
                        sleep_nxt = 1'b1;
                    end else if (do_invert || do_minus || do_skip) begin
                        if (dest_file) begin
                            file_we_nxt = 1'b1;
                            file_waddr_nxt = instr_word[FILE_ADDR_W-1:0];
                            file_wdata_nxt = alu_bus.result;
                        end else begin
                            acc_nxt = alu_bus.result;
                        end
                        if (!do_skip) begin
                            null_nxt = alu_bus.is_null;
                        end else if (alu_bus.is_null) begin
                            state_nxt = CDB_SQUASH;
                        end
                    end else if (do_jump) begin
                        pc_load_nxt = 1'b1;
                        target_nxt = {latch_r[LATCH_HI_BIT:LATCH_LO_BIT],
                                      instr_word[LIT_W-1:0]};
                        state_nxt = CDB_SQUASH;
                    end
                end
                default: begin
                    state_nxt = CDB_EXEC;
                end
            endcase
        end
        // Hardware events win over a kick in the same cycle
        if (watchdog_expire_evt) begin
            expiry_nxt = 1'b0;
        end
        if (sleep_evt) begin
            sleep_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= CDB_EXEC;
            acc_r <= RST_ACC;
            null_r <= RST_NULL;
            expiry_r <= RST_EXPIRY;
            sleep_r <= RST_SLEEP;
            file_we_r <= 1'b0;
            file_waddr_r <= '0;
            file_wdata_r <= '0;
            wd_clear_r <= 1'b0;
            pc_load_r <= 1'b0;
            target_r <= RST_TARGET;
        end else begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            null_r <= null_nxt;
            expiry_r <= expiry_nxt;
            sleep_r <= sleep_nxt;
            file_we_r <= file_we_nxt;
            file_waddr_r <= file_waddr_nxt;
            file_wdata_r <= file_wdata_nxt;
            wd_clear_r <= wd_clear_nxt;
            pc_load_r <= pc_load_nxt;
            target_r <= target_nxt;
        end
    end

    assign file_we = file_we_r;
    assign file_waddr = file_waddr_r;
    assign file_wdata = file_wdata_r;
    assign watchdog_clear = wd_clear_r;
    assign pc_load = pc_load_r;
    assign pc_target = target_r;
    assign squash_active = (state_r == CDB_SQUASH);

    // ************************************************************
    // APB register file
    // ************************************************************
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic setup_phase;
    logic latch_wr;
    logic addr_mapped;
    logic [31:0] rd_mux;

    assign setup_phase = psel && !penable;
    assign latch_wr = psel && penable && pwrite && (paddr == OFS_LATCH);

    always_comb begin
        rd_mux = RDATA_ZERO;
        addr_mapped = 1'b1;
        case (paddr)
            OFS_LATCH: begin
                rd_mux[DATA_W-1:0] = latch_r;
            end
            OFS_STATUS: begin
                rd_mux[ST_NULL_BIT] = null_r;
                rd_mux[ST_SLEEP_BIT] = sleep_r;
                rd_mux[ST_EXPIRY_BIT] = expiry_r;
            end
            OFS_ACC: begin
                rd_mux[DATA_W-1:0] = acc_r;
            end
            OFS_TARGET: begin
                rd_mux[PC_W-1:0] = target_r;
            end
            default: begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        latch_nxt = latch_r;
        if (setup_phase) begin
            prdata_nxt = pwrite ? RDATA_ZERO : rd_mux;
            // Unmapped address, or write to a read-only word
            pslverr_nxt = !addr_mapped || (pwrite && (paddr != OFS_LATCH));
        end
        if (latch_wr) begin
            latch_nxt = pwdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_r <= RDATA_ZERO;
            pslverr_r <= 1'b0;
            latch_r <= RST_LATCH;
        end else begin
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            latch_r <= latch_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = pslverr_r;

endmodule

// File: tb/cdb_exec_sva.sv
`timescale 1ns/1ps
module cdb_exec_sva
    import cdb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Instruction side
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr_word,
    input wire logic [FILE_ADDR_W-1:0] file_raddr,
    input wire logic [DATA_W-1:0] file_rdata,
    // Results
    input wire logic file_we,
    input wire logic [FILE_ADDR_W-1:0] file_waddr,
    input wire logic [DATA_W-1:0] file_wdata,
    input wire logic watchdog_clear,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_target,
    input wire logic squash_active
);
    logic go, is_zero, is_inv, is_min, is_skip, is_jump, is_kick;
    logic [INSTR_W-1:0] word_r;
    assign go = instr_valid && !squash_active;
    assign is_zero = go && ((instr_word & ZEROIZE_MASK) == ZEROIZE_VAL);
    assign is_inv = go && ((instr_word & INVERT_MASK) == INVERT_VAL);
    assign is_min = go && ((instr_word & MINUS_MASK) == MINUS_VAL);
    assign is_skip = go && ((instr_word & SKIP_MASK) == SKIP_VAL);
    assign is_jump = go && ((instr_word & JUMP_MASK) == JUMP_VAL);
    assign is_kick = go && ((instr_word & KICK_MASK) == KICK_VAL);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_r <= '0;
        end else begin
            word_r <= instr_word;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_zeroize_write: assert property (is_zero |=> file_we && file_wdata == 8'h00
        && file_waddr == word_r[6:0]) else $error("zeroize write wrong");
    a_invert_data: assert property (is_inv && instr_word[DEST_BIT] |=> file_we
        && file_wdata == ~$past(file_rdata)) else $error("invert data wrong");
    a_minus_data: assert property ((is_min || is_skip) && instr_word[DEST_BIT] |=> file_we
        && file_wdata == $past(file_rdata) - 8'h01) else $error("decrement data wrong");
    a_acc_dest: assert property ((is_inv || is_min || is_skip) && !instr_word[DEST_BIT]
        |=> !file_we) else $error("accumulator result written to file");
    a_skip_taken: assert property (is_skip && file_rdata == 8'h01 |=> squash_active)
        else $error("zero result did not skip");
    a_skip_not: assert property (is_skip && file_rdata != 8'h01 |=> !squash_active)
        else $error("nonzero result skipped");
    a_jump_load: assert property (is_jump |=> pc_load && squash_active
        && pc_target[10:0] == word_r[10:0]) else $error("jump target wrong");
    a_squash_drop: assert property (instr_valid && squash_active |=> !file_we && !pc_load
        && !watchdog_clear && !squash_active) else $error("discarded slot acted");
    a_kick_cause: assert property (watchdog_clear |-> $past(is_kick))
        else $error("watchdog clear without kick");
    a_kick_clear: assert property (is_kick |=> watchdog_clear)
        else $error("kick did not clear watchdog");
    a_read_addr: assert property (instr_valid |-> file_raddr == instr_word[6:0])
        else $error("file read address wrong");
    c_skip: cover property (is_skip && file_rdata == 8'h01);
    c_jump: cover property (is_jump);
    c_kick: cover property (is_kick);
endmodule
bind cdb_exec cdb_exec_sva u_sva (.core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .watchdog_clear(watchdog_clear),
    .pc_load(pc_load), .pc_target(pc_target), .squash_active(squash_active));

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cdb_pkg::*;
    logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic instr_valid = 0, file_we, watchdog_clear, pc_load, squash_active;
    logic watchdog_expire_evt = 0, sleep_evt = 0;
    logic [13:0] instr_word = '0;
    logic [6:0] file_raddr, file_waddr;
    logic [7:0] file_rdata = '0, file_wdata;
    logic [12:0] pc_target;
    int num_errors = 0, num_checks = 0, cycles = 0;
    always #2.5 core_clk = ~core_clk;
    cdb_exec uut (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_word(instr_word), .file_raddr(file_raddr),
        .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
        .watchdog_clear(watchdog_clear), .watchdog_expire_evt(watchdog_expire_evt),
        .sleep_evt(sleep_evt), .pc_load(pc_load), .pc_target(pc_target), .squash_active(squash_active));
    // ****************************************
    // Helpers
    // ****************************************
    task print_verdict();
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    task chk(logic [31:0] got, logic [31:0] exp, string m);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
            num_errors++;
        end
    endtask
    task apb(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] exp, logic err);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        if (!w) chk(prdata, exp, "read data");
        chk({31'h0, pslverr}, {31'h0, err}, "slave error");
        psel <= 0;
        penable <= 0;
    endtask
    task exec(logic [13:0] w, logic [7:0] d);
        @(posedge core_clk);
        instr_valid <= 1;
        instr_word <= w;
        file_rdata <= d;
        @(posedge core_clk);
        instr_valid <= 0;
        #1;
    endtask
    task wr_chk(logic we, logic [6:0] a, logic [7:0] d);
        chk({31'h0, file_we}, {31'h0, we}, "file write strobe");
        if (we) chk({file_waddr, file_wdata}, {a, d}, "file write");
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_regs();
        apb(0, OFS_STATUS, 0, 32'h0000_0006, 0);
        apb(0, OFS_ACC, 0, 32'h0000_0000, 0);
        apb(0, OFS_TARGET, 0, 32'h0000_0000, 0);
        apb(1, OFS_LATCH, 32'h0000_00A5, 0, 0);
        apb(0, OFS_LATCH, 0, 32'h0000_00A5, 0);
        apb(1, OFS_ACC, 32'h0000_0055, 0, 1);
        apb(0, OFS_ACC, 0, 32'h0000_0000, 0);
        apb(0, 12'h010, 0, 32'h0000_0000, 1);
    endtask
    task t_clear_alu();
        exec(ZEROIZE_VAL | 14'h007F, 8'h33);
        wr_chk(1, 7'h7F, 8'h00);
        apb(0, OFS_STATUS, 0, 32'h0000_0007, 0);
        exec(INVERT_VAL | 14'h0005, 8'h00);
        wr_chk(0, 0, 0);
        apb(0, OFS_ACC, 0, 32'h0000_00FF, 0);
        apb(0, OFS_STATUS, 0, 32'h0000_0006, 0);
        exec(ACC_ZEROIZE_VAL, 8'h12);
        apb(0, OFS_ACC, 0, 32'h0000_0000, 0);
        apb(0, OFS_STATUS, 0, 32'h0000_0007, 0);
        exec(MINUS_VAL | 14'h0011, 8'h00);
        apb(0, OFS_ACC, 0, 32'h0000_00FF, 0);
        apb(0, OFS_STATUS, 0, 32'h0000_0006, 0);
        exec(MINUS_VAL | 14'h0081, 8'h01);
        wr_chk(1, 7'h01, 8'h00);
        apb(0, OFS_STATUS, 0, 32'h0000_0007, 0);
        exec(INVERT_VAL | 14'h00C0, 8'h5A);
        wr_chk(1, 7'h40, 8'hA5);
        apb(0, OFS_STATUS, 0, 32'h0000_0006, 0);
    endtask
    task t_skip();
        exec(SKIP_VAL | 14'h0085, 8'h01);
        wr_chk(1, 7'h05, 8'h00);
        chk({31'h0, squash_active}, 32'h0000_0001, "skip pending");
        apb(0, OFS_STATUS, 0, 32'h0000_0006, 0);
        exec(ZEROIZE_VAL | 14'h0003, 8'h00);
        wr_chk(0, 0, 0);
        exec(SKIP_VAL | 14'h0002, 8'h05);
        chk({31'h0, squash_active}, 32'h0000_0000, "no skip");
        apb(0, OFS_ACC, 0, 32'h0000_0004, 0);
    endtask
    task t_kick();
        @(posedge core_clk);
        sleep_evt <= 1;
        watchdog_expire_evt <= 1;
        @(posedge core_clk);
        sleep_evt <= 0;
        watchdog_expire_evt <= 0;
        apb(0, OFS_STATUS, 0, 32'h0000_0000, 0);
        // Null flag set first, so a kick that disturbs it is seen
        exec(ACC_ZEROIZE_VAL, 8'h00);
        apb(0, OFS_STATUS, 0, 32'h0000_0001, 0);
        exec(KICK_VAL, 8'h00);
        chk({31'h0, watchdog_clear}, 32'h0000_0001, "watchdog clear");
        apb(0, OFS_STATUS, 0, 32'h0000_0007, 0);
    endtask
    task t_jump(logic [7:0] latch, logic [10:0] k, logic [12:0] exp);
        apb(1, OFS_LATCH, {24'h0, latch}, 0, 0);
        exec(JUMP_VAL | {3'h0, k}, 8'h00);
        chk({18'h0, pc_load, pc_target}, {18'h0, 1'b1, exp}, "jump target");
        exec(KICK_VAL, 8'h00);
        chk({31'h0, watchdog_clear}, 32'h0000_0000, "slot after jump");
        apb(0, OFS_TARGET, 0, {19'h0, exp}, 0);
        apb(0, OFS_STATUS, 0, 32'h0000_0007, 0);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1;
        t_regs();
        t_clear_alu();
        t_skip();
        t_kick();
        t_jump(8'h18, 11'h7FF, 13'h1FFF);
        t_jump(8'hE7, 11'h2AA, 13'h02AA);
        t_jump(8'h08, 11'h000, 13'h0800);
        print_verdict();
    end
endmodule
